// File: rcbp_buffer.sv
// Summary of operation
// - Acts as 25-bit one-output register or 14-bit two-output register.
// - Fanout select low gives 25-bit arrangement, high gives 14-bit.
// - In 14-bit mode variant select low is first device, high second.
// - All data inputs captured on the rising clock edge.
// - Parity covers the configuration's module-independent inputs only.
// - Odd count of ones over parity and checked bits is an error.
// - Partial parity and error appear two cycles after data capture.
// - Cascade feeds first partial parity to second; second error valid.
// - Error flag held low at least two cycles unless reset.
// - Consecutive errors keep the flag low while they persist.
// - Clock enable, chip selects and termination excluded from parity.
// - In 25-bit mode unused second outputs of CKE, ODT, CS low.
// - Reset pin is asynchronous to the clock.
// - Reset clears registers, forces data and partial parity low.
// - Leaving reset with inputs low keeps outputs low.
// - Both chip selects high freeze data and partial parity outputs.
// - Low-power state one cycle after both selects high freezes error.
// - Reset beats chip-select gating; error flag forced high.
`timescale 1ns/1ps
`default_nettype none

module rcbp_buffer (
	// Clock and resets
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_reset_n,
	// Configuration straps
	input wire logic i_fanout_select,
	input wire logic i_variant_select,
	// Controller inputs
	input wire logic [24:0] i_data,
	input wire logic i_parity_in,
	input wire logic i_reg_chip_select_n,
	// Memory-side outputs
	output logic [13:0] o_buffered_outputs_a,
	output logic [13:0] o_buffered_outputs_b,
	// Parity outputs
	output logic o_partial_parity_out,
	output logic o_parity_error_n,
	output logic o_parity_error_oe,
	// Status
	output logic o_low_power_state
);

	// ------------------------------------------------------------
	// Reset pin synchroniser
	// ------------------------------------------------------------
	logic rst_meta_n;
	logic rst_sync_n;
	logic rst;

	// Two flops before the pin reset is used
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			rst_meta_n <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_n <= i_reset_n;
			rst_sync_n <= rst_meta_n;
		end
	end

	assign rst = i_sys_rst | ~rst_sync_n;

	// ------------------------------------------------------------
	// Configuration decode
	// ------------------------------------------------------------
	rcbp_pkg::rcbp_cfg_t cfg;
	logic [24:0] check_mask;
	logic both_cs_high;

	assign cfg.fanout_select = i_fanout_select;
	assign cfg.variant_select = i_variant_select;
	// Data chip select is D7 in every arrangement
	assign both_cs_high = i_data[6] & i_reg_chip_select_n;

	// Mask selection; dependent signals never in a mask
	always_comb begin
		if (!cfg.fanout_select) begin
			check_mask = rcbp_pkg::MASK_WIDE;
		end else if (!cfg.variant_select) begin
			check_mask = rcbp_pkg::MASK_PAIR_A;
		end else begin
			check_mask = rcbp_pkg::MASK_PAIR_B;
		end
	end

	// ------------------------------------------------------------
	// Output mapping
	// ------------------------------------------------------------
	logic [13:0] next_q_a;
	logic [13:0] next_q_b;

	// Second column carries D15..D25 or a copy of the first column
	always_comb begin
		logic [4:0] src;
		src = rcbp_pkg::WIDE_B_BASE;
		next_q_a = i_data[13:0];
		next_q_b = 14'h0000;
		for (int r = 0; r < rcbp_pkg::ROWS; r++) begin
			if (cfg.fanout_select) begin
				next_q_b[r] = i_data[r];
			end else if (rcbp_pkg::WIDE_B_USED[r]) begin
				next_q_b[r] = i_data[src];
				src = src + 5'h01;
			end else begin
				next_q_b[r] = 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Data register with chip-select gating
	// ------------------------------------------------------------
	// Reset first, then the freeze, then normal capture
	always_ff @(posedge i_clock) begin
		if (rst) begin
			o_buffered_outputs_a <= 14'h0000;
			o_buffered_outputs_b <= 14'h0000;
		end else if (!both_cs_high) begin
			o_buffered_outputs_a <= next_q_a;
			o_buffered_outputs_b <= next_q_b;
		end
	end

	// ------------------------------------------------------------
	// Low-power state
	// ------------------------------------------------------------
	always_ff @(posedge i_clock) begin
		if (rst) begin
			o_low_power_state <= 1'b0;
		end else begin
			o_low_power_state <= both_cs_high;
		end
	end

	// ------------------------------------------------------------
	// Parity pipeline
	// ------------------------------------------------------------
	rcbp_pkg::rcbp_word_t word_cap;
	logic check_xor;
	logic parity_reg;
	logic gated_s2;
	logic next_ppo;

	// Stage one: data word and gate bit; receivers off under reset
	always_ff @(posedge i_clock) begin
		if (rst) begin
			word_cap <= '0;
		end else begin
			word_cap.data <= i_data;
			word_cap.gated <= both_cs_high;
		end
	end

	// Stage two: parity arrives now, one cycle after its word
	always_ff @(posedge i_clock) begin
		if (rst) begin
			check_xor <= 1'b0;
			parity_reg <= 1'b0;
			gated_s2 <= 1'b0;
		end else begin
			check_xor <= ^(word_cap.data & check_mask);
			parity_reg <= i_parity_in;
			gated_s2 <= word_cap.gated;
		end
	end

	assign next_ppo = parity_reg ^ check_xor;

	// Stage three: partial parity, frozen while gated
	always_ff @(posedge i_clock) begin
		if (rst) begin
			o_partial_parity_out <= 1'b0;
		end else if (!gated_s2) begin
			o_partial_parity_out <= next_ppo;
		end
	end

	// ------------------------------------------------------------
	// Error flag
	// ------------------------------------------------------------
	logic [1:0] err_hold;

	// Latch low on error, hold at least two cycles, freeze in low power
	always_ff @(posedge i_clock) begin
		if (rst) begin
			o_parity_error_n <= rcbp_pkg::ERR_N_IDLE;
			err_hold <= 2'h0;
		end else if (!o_low_power_state) begin
			if (next_ppo) begin
				o_parity_error_n <= 1'b0;
				err_hold <= rcbp_pkg::ERR_HOLD_MIN;
			end else if (err_hold != 2'h0) begin
				err_hold <= err_hold - 2'h1;
			end else begin
				o_parity_error_n <= rcbp_pkg::ERR_N_IDLE;
			end
		end
	end

	// Open-drain drive: enable pulls the line low
	assign o_parity_error_oe = ~o_parity_error_n;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (rst);

	logic [1:0] run_age;

	// Cycles since reset released, saturating
	always_ff @(posedge i_clock) begin
		if (rst) begin
			run_age <= 2'h0;
		end else if (run_age != 2'h3) begin
			run_age <= run_age + 2'h1;
		end
	end

	AST_PPO_LATENCY: assert property (
		(run_age == 2'h3 && !$past(both_cs_high, 3))
		|-> o_partial_parity_out ==
		($past(i_parity_in, 2) ^ ^($past(i_data, 3) & $past(check_mask, 3))))
		else $error("partial parity not aligned two cycles after data");

	AST_ERR_MIN2: assert property (
		($fell(o_parity_error_n) && !o_low_power_state) |=> !o_parity_error_n)
		else $error("error flag released after one cycle");

	AST_ERR_SET: assert property (
		(next_ppo && !o_low_power_state) |=> !o_parity_error_n)
		else $error("detected parity error not flagged");

	AST_ERR_RELEASE: assert property (
		(!next_ppo && !o_low_power_state && err_hold == 2'h0) |=> o_parity_error_n)
		else $error("error flag stuck without error");

	AST_ERR_FREEZE: assert property (
		o_low_power_state |=> $stable(o_parity_error_n))
		else $error("error flag changed in low power");

	AST_Q_FREEZE: assert property (
		both_cs_high |=> $stable(o_buffered_outputs_a) && $stable(o_buffered_outputs_b))
		else $error("outputs changed with both chip selects high");

	AST_Q_CAPTURE: assert property (
		!both_cs_high |=> o_buffered_outputs_a == $past(i_data[13:0]))
		else $error("first column does not follow data");

	AST_LPS: assert property (
		##1 o_low_power_state == $past(both_cs_high))
		else $error("low-power state not one cycle after selects");

	AST_WIDE_UNUSED: assert property (
		!i_fanout_select |=> o_buffered_outputs_b[0] == 1'b0 &&
		o_buffered_outputs_b[3] == 1'b0 && o_buffered_outputs_b[6] == 1'b0)
		else $error("unused second outputs not low");

	AST_RESET_FORCE: assert property (@(posedge i_clock) disable iff (1'b0)
		rst |=> o_buffered_outputs_a == 14'h0000 && !o_partial_parity_out &&
		o_parity_error_n)
		else $error("reset did not force outputs");

	// Mapping, gated parity and pin reset checks
	AST_PPO_FREEZE: assert property (
		both_cs_high |-> ##3 $stable(o_partial_parity_out))
		else $error("partial parity changed for a gated word");

	AST_WIDE_B_MAP: assert property (
		(!i_fanout_select && !both_cs_high) |=>
		o_buffered_outputs_b[13:7] == $past(i_data[24:18]) &&
		o_buffered_outputs_b[5:4] == $past(i_data[17:16]) &&
		o_buffered_outputs_b[2:1] == $past(i_data[15:14]))
		else $error("second column does not carry upper data");

	AST_PAIR_COPY: assert property (
		(i_fanout_select && !both_cs_high) |=> o_buffered_outputs_b == $past(i_data[13:0]))
		else $error("second column does not copy first");

	AST_PIN_RESET: assert property (@(posedge i_clock) disable iff (1'b0)
		(!i_reset_n) [*3] |=> o_buffered_outputs_a == 14'h0000 && !o_partial_parity_out &&
		o_parity_error_n)
		else $error("reset pin did not force outputs");

	AST_PIPE_CLEAR: assert property (@(posedge i_clock) disable iff (1'b0)
		rst |=> word_cap.data == 25'h0000000 && !parity_reg && err_hold == 2'h0)
		else $error("pipeline not cleared in reset");

	COV_ERROR: cover property (next_ppo ##1 !o_parity_error_n);
	COV_BURST: cover property (next_ppo [*3]);
	COV_LOW_POWER: cover property (both_cs_high [*2] ##1 !both_cs_high);
	COV_PAIR_B: cover property (i_fanout_select && i_variant_select && next_ppo);
	COV_PPO_HOLD: cover property (both_cs_high ##3 o_partial_parity_out);

endmodule : rcbp_buffer
`default_nettype wire

// File: rcbp_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// Controller side: word passes straight, parity trails by one cycle
module rcbp_ctrl_model (
	// Clock and request
	input wire logic i_clock,
	input wire logic [24:0] i_word,
	input wire logic [24:0] i_mask,
	input wire logic i_bad,
	// Pins toward the buffer
	output logic [24:0] o_data,
	output logic o_parity
);
	assign o_data = i_word;
	// Even parity of last word, inverted on request
	always @(posedge i_clock) begin
		o_parity <= (^(i_word & i_mask)) ^ i_bad;
	end
endmodule : rcbp_ctrl_model
`default_nettype wire

// File: rcbp_pkg.sv
`default_nettype none
package rcbp_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int WIDE_BITS = 25; // Data inputs D1..D25 at bits 0..24
	localparam int ROWS = 14; // Output rows per column

	// ------------------------------------------------------------
	// Parity masks, bit 0 is D1
	// ------------------------------------------------------------
	localparam logic [24:0] MASK_WIDE = 25'h1ffffb6; // D2-3, D5-6, D8-25
	localparam logic [24:0] MASK_PAIR_A = 25'h0003fb6; // D2-3, D5-6, D8-14
	localparam logic [24:0] MASK_PAIR_B = 25'h0001fbf; // D1-6, D8-13

	// ------------------------------------------------------------
	// Second-column source in the wide arrangement
	// ------------------------------------------------------------
	localparam logic [13:0] WIDE_B_USED = 14'h3fb6; // Rows 1, 4, 7 unused
	localparam logic [4:0] WIDE_B_BASE = 5'h0e; // D15 index
	localparam logic [4:0] NO_SRC = 5'h1f;

	// ------------------------------------------------------------
	// Reset values and timing
	// ------------------------------------------------------------
	localparam logic ERR_N_IDLE = 1'b1; // Flag released
	localparam logic [1:0] ERR_HOLD_MIN = 2'h1; // Extra cycles after first low
	localparam int PARITY_LAG = 1; // Parity trails data by one cycle
	localparam int RESULT_LAG = 2; // Result two cycles after capture

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [24:0] data;
		logic gated;
	} rcbp_word_t;

	typedef struct packed {
		logic fanout_select;
		logic variant_select;
	} rcbp_cfg_t;

endpackage : rcbp_pkg
`default_nettype wire

// File: registered_cmd_buffer_parity_bench.sv
`timescale 1ns/1ps
`default_nettype none
module registered_cmd_buffer_parity_bench;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic clk = 1'b0, rst = 1'b1, rst_n = 1'b0, fan = 1'b0, vsel = 1'b0;
	logic csr_n = 1'b0, bad = 1'b0, par, partial_parity_out, err_n, oe, lps;
	logic [24:0] word = 25'h0, mask = rcbp_pkg::MASK_WIDE, data;
	logic [13:0] qa, qb;
	int errors = 0;
	int compares = 0;
	// Clock
	initial forever #2 clk = ~clk;
	rcbp_ctrl_model u_ctrl (.i_clock(clk), .i_word(word), .i_mask(mask), .i_bad(bad),
		.o_data(data), .o_parity(par));
	rcbp_buffer u_dut (.i_clock(clk), .i_sys_rst(rst), .i_reset_n(rst_n),
		.i_fanout_select(fan), .i_variant_select(vsel), .i_data(data),
		.i_parity_in(par), .i_reg_chip_select_n(csr_n), .o_buffered_outputs_a(qa),
		.o_buffered_outputs_b(qb), .o_partial_parity_out(partial_parity_out), .o_parity_error_n(err_n),
		.o_parity_error_oe(oe), .o_low_power_state(lps));
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [24:0] exp, input logic [24:0] got);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick
	task automatic restart(input logic f, input logic v, input logic [24:0] m);
		rst = 1'b1;
		rst_n = 1'b0;
		fan = f;
		vsel = v;
		mask = m;
		word = 25'h0;
		bad = 1'b0;
		tick(10);
		rst = 1'b0;
		rst_n = 1'b1;
		tick(3);
	endtask : restart
	task automatic send(input logic [24:0] w, input logic b);
		word = w;
		bad = b;
		tick(1);
		word = 25'h0;
		bad = 1'b0;
	endtask : send
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_wide();
		logic [24:0] w;
		w = 25'h1ffffbf;
		restart(1'b0, 1'b0, rcbp_pkg::MASK_WIDE);
		send(w, 1'b0);
		check("qa", {11'h0, w[13:0]}, {11'h0, qa});
		check("qb", {11'h0, w[24:18], 1'b0, w[17:16], 1'b0, w[15:14], 1'b0}, {11'h0, qb});
		tick(2);
		check("err", 25'h1, {24'h0, err_n});
		send(25'h0000049, 1'b0);
		tick(2);
		check("err", 25'h1, {24'h0, err_n});
		send(25'h0000002, 1'b1);
		tick(2);
		check("ppo", 25'h1, {24'h0, partial_parity_out});
		check("err", 25'h0, {24'h0, err_n});
		check("oe", 25'h1, {24'h0, oe});
		tick(1);
		check("err", 25'h0, {24'h0, err_n});
		tick(1);
		check("err", 25'h1, {24'h0, err_n});
		$display("test wide done");
	endtask : t_wide
	task automatic t_consec();
		word = 25'h0000002;
		bad = 1'b1;
		tick(3);
		word = 25'h0;
		bad = 1'b0;
		for (int i = 0; i < 4; i++) begin
			check("err", 25'h0, {24'h0, err_n});
			tick(1);
		end
		check("err", 25'h1, {24'h0, err_n});
		$display("test consecutive done");
	endtask : t_consec
	task automatic t_gate();
		csr_n = 1'b1;
		word = 25'h0001234;
		bad = 1'b1;
		tick(1);
		word = 25'h1abcdef;
		bad = 1'b0;
		check("qa", 25'h1234, {11'h0, qa});
		tick(1);
		check("qa", 25'h1234, {11'h0, qa});
		check("lps", 25'h1, {24'h0, lps});
		tick(1);
		check("ppo", 25'h1, {24'h0, partial_parity_out});
		check("err", 25'h1, {24'h0, err_n});
		tick(1);
		check("ppo", 25'h1, {24'h0, partial_parity_out});
		word = 25'h0;
		csr_n = 1'b0;
		tick(1);
		check("lps", 25'h0, {24'h0, lps});
		check("qa", 25'h0, {11'h0, qa});
		tick(2);
		check("ppo", 25'h0, {24'h0, partial_parity_out});
		$display("test gating done");
	endtask : t_gate
	task automatic t_modes();
		for (int v = 0; v < 2; v++) begin
			restart(1'b1, v[0], (v == 1) ? rcbp_pkg::MASK_PAIR_B : rcbp_pkg::MASK_PAIR_A);
			send(25'h1ffffbf, 1'b0);
			check("qa", 25'h3fbf, {11'h0, qa});
			check("qb", 25'h3fbf, {11'h0, qb});
			tick(2);
			check("err", 25'h1, {24'h0, err_n});
			send(25'h0000001, 1'b0);
			tick(2);
			check("err", 25'h1, {24'h0, err_n});
			send(25'h0004000, 1'b1);
			tick(2);
			check("err", 25'h0, {24'h0, err_n});
			check("ppo", 25'h1, {24'h0, partial_parity_out});
		end
		$display("test pair modes done");
	endtask : t_modes
	task automatic t_reset(input logic pin);
		restart(1'b0, 1'b0, rcbp_pkg::MASK_WIDE);
		word = 25'h1ffffbf;
		bad = 1'b1;
		tick(1);
		bad = 1'b0;
		tick(2);
		check("err", 25'h0, {24'h0, err_n});
		if (pin) rst_n = 1'b0;
		else rst = 1'b1;
		tick(pin ? 4 : 1);
		check("qa", 25'h0, {11'h0, qa});
		check("qb", 25'h0, {11'h0, qb});
		check("ppo", 25'h0, {24'h0, partial_parity_out});
		check("err", 25'h1, {24'h0, err_n});
		restart(1'b0, 1'b0, rcbp_pkg::MASK_WIDE);
		check("qa", 25'h0, {11'h0, qa});
		$display("test reset done");
	endtask : t_reset
	// ------------------------------------------------------------
	// Verdict and sequence
	// ------------------------------------------------------------
	task automatic end_of_test();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : end_of_test
	// Main sequence
	initial begin
		t_wide();
		t_consec();
		t_gate();
		t_modes();
		t_reset(1'b0);
		t_reset(1'b1);
		end_of_test();
	end
	// Watchdog
	initial begin
		#20000;
		errors++;
		end_of_test();
	end
endmodule : registered_cmd_buffer_parity_bench
`default_nettype wire
